// [xpc_consts.svh]
`ifndef XPC_CONSTS_SVH
`define XPC_CONSTS_SVH
// Summary of operation
// - Duplex bit: one full, zero half; resets one.
// - Transmit flow control only when enabled; resets zero.
// - Receive flow control only when enabled; resets zero.
// - Without gigabit: 10/100 bit picks speed.
// - Gigabit bit set: RGMII runs 1000 Mb/s.
// - Ingress clock delay enable; resets zero.
// - Egress clock delay enable; resets one.
// - MII: mode one accepts clocks, zero drives.
// - RMII: mode one receives refclk, zero drives.
// - RGMII: mode bit enables in-band status.
// - Type code: 00 MII, 01 RMII, 11 RGMII.
// - Gigabit, mode, type reset from strap pins.
// - In-band status readable in port 3 register.
// - In-band duplex: one full, zero half.
// - Speed code: 10 gig, 01 100, 00 10.
// - In-band link: one up, zero down.
// Register indices; byte address is index times four
`define XPC_IDX_CTL0 14'h3300
`define XPC_IDX_CTL1 14'h3301
`define XPC_IDX_CTL3 14'h3303
// Field positions
`define XPC_C0_DUPLEX 6
`define XPC_C0_TXFC 5
`define XPC_C0_SP100 4
`define XPC_C0_RXFC 3
`define XPC_C1_GIG 6
`define XPC_C1_RXDLY 4
`define XPC_C1_TXDLY 3
`define XPC_C1_MODE 2
// Reset values
`define XPC_CTL0_RST 7'h50
`define XPC_CTL1_RST 8'h08
// Timing
`define XPC_SYS_HZ 100000000
`define XPC_RMII_REF_HZ 50000000
`define XPC_MII_100_HZ 25000000
`define XPC_MII_10_HZ 2500000
`define XPC_CLK_DELAY_PS 1500
`define XPC_STRAP_SETTLE 2'h2
`define XPC_LRST_STRETCH 6'h3f
`endif

// [xpc_pkg.sv]
package xpc_pkg;

  // Interface type as decoded from the two-bit field
  typedef enum logic [1:0] {IF_MII, IF_RMII, IF_RSVD, IF_RGMII} xpc_if_e;

  // Port rate
  typedef enum logic [1:0] {SPD_10, SPD_100, SPD_1000} xpc_speed_e;

  // Configuration handed to the port MAC and pad logic
  typedef struct packed {
    logic full_duplex;
    logic tx_flow_en;
    logic rx_flow_en;
    xpc_speed_e speed;
    logic rx_clock_delay_enable;
    logic tx_clock_delay_enable;
    xpc_if_e if_type;
    logic mac_mode;
    logic inband_en;
  } xpc_cfg_s;

  // In-band status as reported by the attached PHY
  typedef struct packed {
    logic duplex;
    logic [1:0] rclk_speed;
    logic link;
  } xpc_ibs_s;

endpackage : xpc_pkg

// [xpc_port_cfg.sv]
`timescale 1ns/1ps
`include "xpc_consts.svh"

module xpc_port_cfg
  import xpc_pkg::*;
(
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Configuration straps
  input wire logic gigabit_strap_pin_i,
  input wire logic mode_strap_pin_i,
  input wire logic [1:0] if_type_strap_i,
  // RGMII receive side, link clock domain
  input wire logic rx_link_clk_i,
  input wire logic [3:0] rxd_i,
  input wire logic rx_ctl_i,
  // Receive clock pin, two-way
  input wire logic receive_clock_pin_i,
  output logic receive_clock_pin_o,
  output logic receive_clock_pin_oe_o,
  // Decoded configuration and status
  output xpc_cfg_s cfg_o,
  output xpc_ibs_s ibs_o
);

  // Speed selection from the gigabit and 10/100 bits
  function automatic xpc_speed_e speed_of(input logic gig, input logic sp100);
    if (gig)
      return SPD_1000;
    return sp100 ? SPD_100 : SPD_10;
  endfunction : speed_of

  // Interface type decode, every code listed
  function automatic xpc_if_e type_of(input logic [1:0] code);
    xpc_if_e t;
    t = IF_MII;
    unique case (code)
      2'h0: t = IF_MII;
      2'h1: t = IF_RMII;
      2'h2: t = IF_RSVD;
      2'h3: t = IF_RGMII;
    endcase
    return t;
  endfunction : type_of

  // Half-period of the driven receive clock in system cycles
  function automatic logic [7:0] half_of(input xpc_if_e t, input xpc_speed_e s);
    int h;
    h = `XPC_SYS_HZ / (2 * `XPC_MII_10_HZ);
    if (t == IF_RMII)
      h = `XPC_SYS_HZ / (2 * `XPC_RMII_REF_HZ);
    else if (s != SPD_10)
      h = `XPC_SYS_HZ / (2 * `XPC_MII_100_HZ);
    return h[7:0];
  endfunction : half_of

  logic [6:0] ctl0_r;
  logic [7:0] ctl1_r;
  logic [3:0] ctl3_rsv_r;
  logic [3:0] strap_s1_r;
  logic [3:0] strap_s2_r;
  logic [3:0] strap_s3_r;
  logic [1:0] strap_cnt_r;
  logic strap_done_r;
  logic strap_load;
  logic bus_req;
  logic wr_en;
  logic [13:0] idx;
  logic [7:0] div_cnt_r;
  logic drive_nxt;
  logic [2:0] req_s_r;
  logic seen_r;
  logic take;
  logic [2:0] lrst_s_r;
  logic [2:0] len_s_r;
  logic [2:0] ack_s_r;
  logic [3:0] hold_r;
  logic req_tgl_r;
  logic [5:0] lrst_cnt_r;
  logic lrst_hold_r;

  assign bus_req = wb_cyc_i && wb_stb_i;
  assign idx = wb_adr_i[15:2];
  // Write lands on the edge where the master sees ack
  assign wr_en = bus_req && wb_we_i && wb_ack_o && wb_sel_i[0];

  // Strap pins pass three stages before use
  always_ff @(posedge clk_i)
  begin
    strap_s1_r <= {gigabit_strap_pin_i, mode_strap_pin_i, if_type_strap_i};
    strap_s2_r <= strap_s1_r;
    strap_s3_r <= strap_s2_r;
  end

  // Straps settle after reset, then load once when stable
  assign strap_load = !strap_done_r && strap_cnt_r == `XPC_STRAP_SETTLE && strap_s2_r == strap_s3_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      strap_cnt_r <= 2'h0;
      strap_done_r <= 1'b0;
    end
    else
    begin
      if (strap_cnt_r != `XPC_STRAP_SETTLE)
        strap_cnt_r <= strap_cnt_r + 2'h1;
      if (strap_load)
        strap_done_r <= 1'b1;
    end
  end

  // Bus answer; held back until straps are loaded
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= bus_req && !wb_ack_o && strap_done_r;
  end

  // Read data captured with ack; unmapped reads return zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0;
    else if (bus_req && !wb_ack_o)
    begin
      wb_dat_o <= 32'h0;
      unique case (idx)
        `XPC_IDX_CTL0: wb_dat_o[7:0] <= {1'b0, ctl0_r};
        `XPC_IDX_CTL1: wb_dat_o[7:0] <= ctl1_r;
        `XPC_IDX_CTL3: wb_dat_o[7:0] <= {ctl3_rsv_r, ibs_o};
        default: wb_dat_o <= 32'h0;
      endcase
    end
  end

  // Link control register; bit 7 reads zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctl0_r <= `XPC_CTL0_RST;
    else if (wr_en && idx == `XPC_IDX_CTL0)
      ctl0_r <= wb_dat_i[6:0];
  end

  // Interface select register; strap fields loaded after reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctl1_r <= `XPC_CTL1_RST;
    else if (strap_load)
    begin
      ctl1_r[`XPC_C1_GIG] <= strap_s3_r[3];
      ctl1_r[`XPC_C1_MODE] <= strap_s3_r[2];
      ctl1_r[1:0] <= strap_s3_r[1:0];
    end
    else if (wr_en && idx == `XPC_IDX_CTL1)
      ctl1_r <= wb_dat_i[7:0];
  end

  // Upper nibble of the status register is plain storage
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctl3_rsv_r <= 4'h0;
    else if (wr_en && idx == `XPC_IDX_CTL3)
      ctl3_rsv_r <= wb_dat_i[7:4];
  end

  // Decoded configuration, one cycle behind the registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cfg_o <= '0;
    else
    begin
      cfg_o.full_duplex <= ctl0_r[`XPC_C0_DUPLEX];
      cfg_o.tx_flow_en <= ctl0_r[`XPC_C0_TXFC];
      cfg_o.rx_flow_en <= ctl0_r[`XPC_C0_RXFC];
      cfg_o.speed <= speed_of(ctl1_r[`XPC_C1_GIG], ctl0_r[`XPC_C0_SP100]);
      // Pad delay cells need at least XPC_CLK_DELAY_PS when enabled
      cfg_o.rx_clock_delay_enable <= ctl1_r[`XPC_C1_RXDLY];
      cfg_o.tx_clock_delay_enable <= ctl1_r[`XPC_C1_TXDLY];
      cfg_o.if_type <= type_of(ctl1_r[1:0]);
      cfg_o.mac_mode <= ctl1_r[`XPC_C1_MODE];
      cfg_o.inband_en <= ctl1_r[`XPC_C1_MODE] && type_of(ctl1_r[1:0]) == IF_RGMII;
    end
  end

  // MII as PHY and RMII as clock source drive the pin
  assign drive_nxt = !cfg_o.mac_mode && (cfg_o.if_type == IF_MII || cfg_o.if_type == IF_RMII);

  // Receive clock divider from the system clock
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !drive_nxt)
    begin
      div_cnt_r <= 8'h0;
      receive_clock_pin_o <= 1'b0;
    end
    else if (div_cnt_r >= half_of(cfg_o.if_type, cfg_o.speed) - 8'h1)
    begin
      div_cnt_r <= 8'h0;
      receive_clock_pin_o <= !receive_clock_pin_o;
    end
    else
      div_cnt_r <= div_cnt_r + 8'h1;
  end

  // Pin enable; a reserved type leaves the pin undriven
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      receive_clock_pin_oe_o <= 1'b0;
    else
      receive_clock_pin_oe_o <= drive_nxt;
  end

  // Short resets are stretched so several slow link edges see them
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lrst_cnt_r <= `XPC_LRST_STRETCH;
      lrst_hold_r <= 1'b1;
    end
    else
    begin
      if (lrst_cnt_r != 6'h0)
        lrst_cnt_r <= lrst_cnt_r - 6'h1;
      lrst_hold_r <= lrst_cnt_r != 6'h0;
    end
  end

  // Reset and enable into the link domain, three stages each
  always_ff @(posedge rx_link_clk_i)
  begin
    lrst_s_r <= {lrst_s_r[1:0], lrst_hold_r};
    len_s_r <= {len_s_r[1:0], cfg_o.inband_en};
    ack_s_r <= {ack_s_r[1:0], seen_r};
  end

  // Capture a new status code in the gap; one word in flight
  always_ff @(posedge rx_link_clk_i)
  begin
    if (lrst_s_r[2])
    begin
      hold_r <= 4'h0;
      req_tgl_r <= 1'b0;
    end
    else if (len_s_r[2] && !rx_ctl_i && ack_s_r[2] == req_tgl_r && rxd_i != hold_r)
    begin
      hold_r <= rxd_i;
      req_tgl_r <= !req_tgl_r;
    end
  end

  // Request toggle into the system domain
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      req_s_r <= 3'h0;
    else
      req_s_r <= {req_s_r[1:0], req_tgl_r};
  end

  // A change counts once the second and third stages agree
  assign take = req_s_r[1] == req_s_r[2] && req_s_r[2] != seen_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      seen_r <= 1'b0;
    else if (take)
      seen_r <= req_s_r[2];
  end

  // Held word is stable until the acknowledge returns
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ibs_o <= '0;
    else if (take && cfg_o.inband_en)
      ibs_o <= hold_r;
  end

  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_duplex_write: assert property (wr_en && idx == `XPC_IDX_CTL0 |->
    ##2 cfg_o.full_duplex == $past(wb_dat_i[6], 2))
    else $error("duplex output does not follow write");

  a_txfc_write: assert property (wr_en && idx == `XPC_IDX_CTL0 |->
    ##2 cfg_o.tx_flow_en == $past(wb_dat_i[5], 2))
    else $error("transmit flow control does not follow write");

  a_rxfc_write: assert property (wr_en && idx == `XPC_IDX_CTL0 |->
    ##2 cfg_o.rx_flow_en == $past(wb_dat_i[3], 2))
    else $error("receive flow control does not follow write");

  a_speed_low: assert property (!ctl1_r[6] && !ctl0_r[4] |=> cfg_o.speed == SPD_10)
    else $error("10/100 bit zero must give 10 Mb/s");

  a_speed_gig: assert property (ctl1_r[6] |=> cfg_o.speed == SPD_1000)
    else $error("gigabit bit must override 10/100 bit");

  a_delay_write: assert property (wr_en && idx == `XPC_IDX_CTL1 && !strap_load |->
    ##2 cfg_o.rx_clock_delay_enable == $past(wb_dat_i[4], 2)
    && cfg_o.tx_clock_delay_enable == $past(wb_dat_i[3], 2))
    else $error("clock delay enables do not follow write");

  a_mac_no_drive: assert property (cfg_o.if_type == IF_MII && cfg_o.mac_mode |=>
    !receive_clock_pin_oe_o)
    else $error("MAC mode must not drive the receive clock");

  a_refclk_toggle: assert property ((cfg_o.if_type == IF_RMII && !cfg_o.mac_mode) [*3] |=>
    receive_clock_pin_oe_o && $changed(receive_clock_pin_o))
    else $error("reference clock not generated every cycle");

  a_type_rgmii: assert property (wr_en && idx == `XPC_IDX_CTL1 && wb_dat_i[1:0] == 2'h3 |->
    ##2 cfg_o.if_type == IF_RGMII)
    else $error("type code 11 must select RGMII");

  a_strap_load: assert property ($rose(strap_done_r) |->
    ctl1_r[6] == $past(strap_s3_r[3]) && ctl1_r[2] == $past(strap_s3_r[2])
    && ctl1_r[1:0] == $past(strap_s3_r[1:0]))
    else $error("strap values not loaded");

  a_ibs_update: assert property (take && cfg_o.inband_en |=> ibs_o == $past(hold_r))
    else $error("in-band status not taken");

  a_ibs_hold: assert property (!cfg_o.inband_en |=> $stable(ibs_o))
    else $error("status changed while in-band disabled");

  a_ack_pulse: assert property (bus_req && !wb_ack_o && strap_done_r |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack must be a single cycle");

  c_ibs_taken: cover property (take && cfg_o.inband_en);
  c_rmii_drive: cover property (receive_clock_pin_oe_o && cfg_o.if_type == IF_RMII);
  c_mii_phy_drive: cover property (receive_clock_pin_oe_o && cfg_o.if_type == IF_MII);
  c_strap_done: cover property ($rose(strap_done_r));

endmodule : xpc_port_cfg

// [xpc_phy_model.sv]
`timescale 1ns/1ps

module xpc_phy_model
(
  // Link side
  input wire logic rx_link_clk_i,
  input wire logic [3:0] status_i,
  input wire logic frame_i,
  output logic [3:0] rxd_o,
  output logic rx_ctl_o
);
  // Status nibble {duplex, speed, link} between frames, busy pattern inside them
  always_ff @(posedge rx_link_clk_i)
  begin
    rx_ctl_o <= frame_i;
    rxd_o <= frame_i ? ~rxd_o : status_i;
  end
endmodule : xpc_phy_model

// [xpc_port_cfg_bench.sv]
`timescale 1ns/1ps
`include "xpc_consts.svh"

module xpc_port_cfg_bench
  import xpc_pkg::*;
;
  // Design stretches reset into the slow link domain itself
  localparam int RST_CYC = 8;
  localparam logic [15:0] CORNER [8] = '{16'h1001, 16'h5005, 16'h1000, 16'h0000,
                                         16'h5004, 16'h7802, 16'h4847, 16'h2018};
  logic clk_i = 0, rst_i = 1, lclk = 0, cyc = 0, stb = 0, we = 0;
  logic g_s = 1, m_s = 1, frame = 0, rx_ctl, pin_o, pin_oe, ack, p;
  logic [1:0] t_s = 2'h3;
  logic [3:0] code = 4'h0, rxd;
  logic [15:0] adr = 16'h0;
  logic [31:0] dat = 32'h0, rdat;
  logic [7:0] q, c0, c1;
  xpc_cfg_s cfg;
  xpc_ibs_s inband_link_report;
  int num_errors = 0, samples_checked = 0, cycles = 0, tog;
  wire pin_i = pin_oe ? pin_o : lclk;

  // Clocks, link clock unrelated in phase
  initial forever #5 clk_i = ~clk_i;
  initial
  begin
    #3.1;
    forever #62.5 lclk = ~lclk;
  end

  xpc_port_cfg dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .gigabit_strap_pin_i(g_s), .mode_strap_pin_i(m_s), .if_type_strap_i(t_s),
    .rx_link_clk_i(lclk), .rxd_i(rxd), .rx_ctl_i(rx_ctl), .receive_clock_pin_i(pin_i),
    .receive_clock_pin_o(pin_o), .receive_clock_pin_oe_o(pin_oe), .cfg_o(cfg), .ibs_o(inband_link_report));
  xpc_phy_model phy (.rx_link_clk_i(lclk), .status_i(code), .frame_i(frame), .rxd_o(rxd),
    .rx_ctl_o(rx_ctl));

  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chkc(input xpc_cfg_s got, input xpc_cfg_s exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %0t config %h expected %h", $time, got, exp);
    end
  endtask : chkc

  // One classic cycle; holds everything until ack is sampled
  task automatic wb(input logic w, input logic [13:0] idx, input logic [7:0] d, output logic [7:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= {idx, 2'h0};
    dat <= {24'h0, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 200);
    if (ack !== 1'b1)
    begin
      num_errors++;
      $display("CHECK FAILED %0t bus cycle never acknowledged", $time);
    end
    r = rdat[7:0];
    cyc <= 0;
    stb <= 0;
  endtask : wb

  task automatic rst(input logic g, input logic m, input logic [1:0] t);
    g_s <= g;
    m_s <= m;
    t_s <= t;
    rst_i <= 1;
    repeat (RST_CYC) @(posedge clk_i);
    rst_i <= 0;
  endtask : rst

  function automatic xpc_cfg_s exp_cfg(input logic [7:0] a, input logic [7:0] b);
    return '{a[6], a[5], a[3], b[6] ? SPD_1000 : (a[4] ? SPD_100 : SPD_10), b[4], b[3],
             xpc_if_e'(b[1:0]), b[2], b[2] && b[1:0] == 2'h3};
  endfunction : exp_cfg

  // Pin edges expected in 40 cycles: divider only when driving
  function automatic logic [7:0] exp_tog(input logic [7:0] a, input logic [7:0] b);
    if (b[2] || b[1]) return 8'h0;
    return b[0] ? 8'd40 : (a[4] ? 8'd20 : 8'd2);
  endfunction : exp_tog

  task automatic setcfg(input logic [7:0] a, input logic [7:0] b);
    wb(1, `XPC_IDX_CTL0, a, q);
    wb(1, `XPC_IDX_CTL1, b, q);
    repeat (3) @(posedge clk_i);
    chkc(cfg, exp_cfg(a, b));
    wb(0, `XPC_IDX_CTL0, 8'h0, q);
    chk8(q, {1'b0, a[6:0]});
  endtask : setcfg

  task automatic wait_ibs(input logic [3:0] c);
    int n;
    n = 0;
    while (inband_link_report !== c && n < 300)
    begin
      @(posedge clk_i);
      n++;
    end
  endtask : wait_ibs

  // Hang guard
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      num_errors++;
      $display("CHECK FAILED %0t run too long", $time);
      conclude();
    end
  end

  initial
  begin
    void'($urandom(67));
    rst(1'b1, 1'b1, 2'h3);
    wb(0, `XPC_IDX_CTL0, 8'h0, q);
    chk8(q, 8'h50);
    wb(0, `XPC_IDX_CTL1, 8'h0, q);
    chk8(q, 8'h4f);
    chkc(cfg, exp_cfg(8'h50, 8'h4f));
    wb(1, 14'h3302, 8'hff, q);
    wb(0, 14'h3302, 8'h0, q);
    chk8(q, 8'h00);
    foreach (CORNER[i])
    begin
      setcfg(CORNER[i][15:8], CORNER[i][7:0]);
      tog = 0;
      p = pin_o;
      repeat (40)
      begin
        @(posedge clk_i);
        tog += int'(pin_o !== p);
        p = pin_o;
      end
      chk8(8'(tog), exp_tog(CORNER[i][15:8], CORNER[i][7:0]));
      chk8({7'h0, pin_oe}, {7'h0, exp_tog(CORNER[i][15:8], CORNER[i][7:0]) != 8'h0});
    end
    repeat (16)
    begin
      c0 = 8'($urandom);
      c1 = 8'($urandom);
      setcfg(c0, c1);
    end
    setcfg(8'h50, 8'h47);
    for (int k = 0; k < 16; k++)
    begin
      code <= 4'(k);
      wait_ibs(4'(k));
      chk8({4'h0, inband_link_report}, 8'(k));
      wb(0, `XPC_IDX_CTL3, 8'h0, q);
      chk8({4'h0, q[3:0]}, 8'(k));
    end
    frame <= 1;
    code <= 4'h5;
    repeat (150) @(posedge clk_i);
    chk8({4'h0, inband_link_report}, 8'h0f);
    frame <= 0;
    wait_ibs(4'h5);
    chk8({4'h0, inband_link_report}, 8'h05);
    setcfg(8'h50, 8'h43);
    code <= 4'h9;
    repeat (150) @(posedge clk_i);
    chk8({4'h0, inband_link_report}, 8'h05);
    rst(1'b0, 1'b0, 2'h1);
    wb(0, `XPC_IDX_CTL1, 8'h0, q);
    chk8(q, 8'h09);
    conclude();
  end
endmodule : xpc_port_cfg_bench
